// >>> uaf_fifo.sv
// ==========================================================================
// shared constants
package uaf_pkg;
  localparam int CHAR_W = 8;               // data bits per character
  localparam int ERR_W = 3;                // error status bits per rx entry
  localparam int RX_W = CHAR_W + ERR_W;    // rx queue entry width
  localparam int RX_DEPTH = 16;            // rx queue depth in characters
  localparam int TX_DEPTH = 16;            // tx queue depth in characters
  localparam int LVL_W = 5;                // width of a fill level
  localparam int MCR_W = 8;                // modem control byte width
  localparam int MSR_W = 8;                // modem status byte width
  localparam int MCR_RTS_BIT = 1;          // modem control: rts request
  localparam int MCR_AFE_BIT = 5;          // modem control: autoflow enable
  localparam int MSR_DCTS_BIT = 0;         // modem status: cts changed
  localparam int MSR_CTS_BIT = 4;          // modem status: cts level

  // rx trigger level selection
  typedef enum logic [1:0] {
    TRIG_1 = 2'b00,
    TRIG_4 = 2'b01,
    TRIG_8 = 2'b10,
    TRIG_14 = 2'b11
  } uaf_trig_e;

  localparam logic [4:0] LVL_EMPTY = 5'h00;
  localparam logic [4:0] LVL_1 = 5'h01;
  localparam logic [4:0] LVL_4 = 5'h04;
  localparam logic [4:0] LVL_8 = 5'h08;
  localparam logic [4:0] LVL_14 = 5'h0e;
  localparam logic [4:0] LVL_ONE_FREE = 5'h0f;
  localparam logic [4:0] LVL_FULL = 5'h10;

  // fill level that a trigger code stands for
  function automatic logic [4:0] trig_to_level(input uaf_trig_e t);
    case (t)
      TRIG_1: trig_to_level = LVL_1;
      TRIG_4: trig_to_level = LVL_4;
      TRIG_8: trig_to_level = LVL_8;
      default: trig_to_level = LVL_14;
    endcase
  endfunction : trig_to_level
endpackage : uaf_pkg

`timescale 1ns/10ps

// ==========================================================================
// synchronous fifo, first word fall through
module uaf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,                       // system clock
  input wire logic rst,                           // async reset, high
  input wire logic in_valid,                      // write request
  output logic in_ready,                          // room for a word
  input wire logic [WIDTH-1:0] in_data,           // write data
  output logic out_valid,                         // head word present
  input wire logic out_ready,                     // pop head word
  output logic [WIDTH-1:0] out_data,              // head word
  output logic [$clog2(DEPTH+1)-1:0] level        // words held
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);
  localparam logic [LW-1:0] ONE = LW'(1);

  // pointers wrap naturally, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("uaf_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [LW-1:0] count_q;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready = (count_q != FULL);
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign level = count_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, it is only read when counted valid
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + ONE;
      end else if (pop && !push) begin
        count_q <= count_q - ONE;
      end
    end
  end
endmodule : uaf_fifo

// >>> uaf_autoflow.sv
`timescale 1ns/10ps

// Notes on behaviour
// - autoflow works only while fifo mode is on
// - both queues hold 16; rx adds three error bits
// - auto cts: no character starts while cts inactive
// - cts sampled before each character start
// - no cts interrupt while flow control runs
// - without auto cts, queued characters always go
// - auto rts: rts active while receiver has room
// - trigger 1/4/8: rts drops at trigger level
// - trigger 1/4/8: one more character still accepted
// - trigger 1/4/8: rts returns once queue empty
// - trigger 14: drop at sixteenth character's data
// - trigger 14: rts returns with a free slot
// - one free and idle, or two free
// - full queue: first read brings rts back
// - auto rts needs afe and rts control bits set; auto cts needs afe only
// - status shows cts level and change flag
// - cts change interrupt only outside auto cts
module uaf_autoflow (
  input wire logic sys_clk,                        // 20 MHz system clock
  input wire logic rst,                            // async reset, high
  input wire logic fifo_mode,                      // fifo mode enabled
  input wire logic [uaf_pkg::MCR_W-1:0] modem_ctrl, // modem control byte
  input wire logic [1:0] rx_trigger,               // rx trigger code
  input wire logic modem_irq_en,                   // modem status irq enable
  input wire logic modem_status_rd,                // status read pulse
  input wire logic cts_n,                          // clear to send pin
  output logic rts_n_q,                            // request to send pin
  output logic [uaf_pkg::MSR_W-1:0] modem_status_q, // modem status byte
  output logic modem_irq_q,                        // modem status irq
  input wire logic rx_char_valid,                  // received char pulse
  input wire logic [uaf_pkg::RX_W-1:0] rx_char,    // char plus error bits
  input wire logic rx_first_data,                  // first data bit seen
  output logic rx_overrun_q,                       // char lost, queue full
  input wire logic receive_buffer_rd,              // cpu read pulse
  output logic [uaf_pkg::RX_W-1:0] receive_buffer_q, // read data
  output logic receive_buffer_vld_q,               // read data valid
  output logic [uaf_pkg::LVL_W-1:0] rx_level_q,    // rx queue fill
  input wire logic thr_wr_valid,                   // cpu tx write
  input wire logic [uaf_pkg::CHAR_W-1:0] thr_wr_data, // cpu tx data
  output logic thr_wr_ready_q,                     // tx queue has room
  input wire logic tx_ready,                       // shifter takes a char
  output logic tx_start_q,                         // char launch pulse
  output logic [uaf_pkg::CHAR_W-1:0] tx_data_q     // launched char
);
  // ========================================================================
  // mode decode
  logic afe;
  logic rts_bit;
  logic auto_cts;
  logic auto_rts;
  uaf_pkg::uaf_trig_e trig;

  // rts bit clear leaves cts only
  assign afe = modem_ctrl[uaf_pkg::MCR_AFE_BIT];
  assign rts_bit = modem_ctrl[uaf_pkg::MCR_RTS_BIT];
  assign auto_cts = fifo_mode && afe;
  assign auto_rts = fifo_mode && afe && rts_bit;
  assign trig = uaf_pkg::uaf_trig_e'(rx_trigger);

  // ========================================================================
  // cts synchroniser
  logic cts_meta_q;
  logic cts_sync_q;
  logic cts_prev_q;
  logic cts_active;
  logic cts_changed;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cts_meta_q <= 1'b1;
      cts_sync_q <= 1'b1;
      cts_prev_q <= 1'b1;
    end else begin
      cts_meta_q <= cts_n;
      cts_sync_q <= cts_meta_q;
      cts_prev_q <= cts_sync_q;
    end
  end

  // pin is active low
  assign cts_active = !cts_sync_q;
  assign cts_changed = (cts_sync_q != cts_prev_q);

  // ========================================================================
  // modem status and interrupt
  // level, sticky change, read clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modem_status_q <= '0;
    end else begin
      modem_status_q[uaf_pkg::MSR_CTS_BIT] <= cts_active;
      // set wins over the clearing read
      if (cts_changed) begin
        modem_status_q[uaf_pkg::MSR_DCTS_BIT] <= 1'b1;
      end else if (modem_status_rd) begin
        modem_status_q[uaf_pkg::MSR_DCTS_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modem_irq_q <= 1'b0;
    end else if (cts_changed && modem_irq_en && !auto_cts) begin
      modem_irq_q <= 1'b1;
    end else if (modem_status_rd || !modem_irq_en) begin
      modem_irq_q <= 1'b0;
    end
  end

  // ========================================================================
  // receive queue
  logic rx_in_ready;
  logic rx_out_valid;
  logic rx_pop;
  logic [uaf_pkg::RX_W-1:0] rx_head;
  logic [uaf_pkg::LVL_W-1:0] rx_level;

  assign rx_pop = receive_buffer_rd && rx_out_valid;

  uaf_fifo #(
    .WIDTH(uaf_pkg::RX_W),
    .DEPTH(uaf_pkg::RX_DEPTH)
  ) u_rx_queue (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_char_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_char),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_head),
    .level(rx_level)
  );

  // cpu side read data, one cycle after the read pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      receive_buffer_q <= '0;
      receive_buffer_vld_q <= 1'b0;
      rx_overrun_q <= 1'b0;
      rx_level_q <= '0;
    end else begin
      receive_buffer_vld_q <= rx_pop;
      if (rx_pop) begin
        receive_buffer_q <= rx_head;
      end
      // a full queue drops the new character, not the old ones
      rx_overrun_q <= rx_char_valid && !rx_in_ready;
      rx_level_q <= rx_level;
    end
  end

  // ========================================================================
  // auto rts
  logic rx_inchar_q;
  logic hold_low_q;
  logic hold_14;

  // a character is in progress from its first data bit to its end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_inchar_q <= 1'b0;
    end else if (rx_char_valid) begin
      rx_inchar_q <= 1'b0;
    end else if (rx_first_data) begin
      rx_inchar_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_low_q <= 1'b0;
    end else if (rx_level >= uaf_pkg::trig_to_level(trig)) begin
      hold_low_q <= 1'b1;
    end else if (rx_level == uaf_pkg::LVL_EMPTY) begin
      hold_low_q <= 1'b0;
    end
  end

  // full, or one free with char arriving
  assign hold_14 = (rx_level == uaf_pkg::LVL_FULL) ||
                   ((rx_level == uaf_pkg::LVL_ONE_FREE) && rx_inchar_q);

  // queue still takes the extra char
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rts_n_q <= 1'b1;
    end else if (!auto_rts) begin
      rts_n_q <= !rts_bit;
    end else if (trig == uaf_pkg::TRIG_14) begin
      rts_n_q <= hold_14;
    end else begin
      rts_n_q <= hold_low_q;
    end
  end

  // ========================================================================
  // transmit queue and auto cts gate
  logic tx_push;
  logic tx_out_valid;
  logic tx_launch;
  logic [uaf_pkg::CHAR_W-1:0] tx_head;
  logic [uaf_pkg::LVL_W-1:0] tx_level;

  // ready is registered, so it ignores a same-cycle pop: conservative
  assign tx_push = thr_wr_valid && thr_wr_ready_q;

  // late cts release is the far end's fault
  assign tx_launch = tx_ready && tx_out_valid && !tx_start_q &&
                     (!auto_cts || cts_active);

  uaf_fifo #(
    .WIDTH(uaf_pkg::CHAR_W),
    .DEPTH(uaf_pkg::TX_DEPTH)
  ) u_tx_queue (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(tx_push),
    .in_ready(),
    .in_data(thr_wr_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_launch),
    .out_data(tx_head),
    .level(tx_level)
  );

  // launch pulse and room indication
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_start_q <= 1'b0;
      tx_data_q <= '0;
      thr_wr_ready_q <= 1'b0;
    end else begin
      tx_start_q <= tx_launch;
      if (tx_launch) begin
        tx_data_q <= tx_head;
      end
      thr_wr_ready_q <= (tx_level + {4'h0, tx_push}) <
                        uaf_pkg::LVL_W'(uaf_pkg::TX_DEPTH);
    end
  end

  // ========================================================================
  // assertions
  property p_cts_gate;
    @(posedge sys_clk) disable iff (rst)
    (tx_start_q && $past(auto_cts)) |-> $past(cts_active);
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("character started while cts inactive");

  property p_free_send;
    @(posedge sys_clk) disable iff (rst)
    (!auto_cts && tx_ready && tx_out_valid && !tx_start_q) |=> tx_start_q;
  endproperty
  a_free_send: assert property (p_free_send)
    else $error("queued character held without auto cts");

  property p_rts_drop;
    @(posedge sys_clk) disable iff (rst)
    (auto_rts && trig != uaf_pkg::TRIG_14 &&
     rx_level >= uaf_pkg::trig_to_level(trig)) |=> ##1 rts_n_q;
  endproperty
  a_rts_drop: assert property (p_rts_drop)
    else $error("rts still active at trigger level");

  property p_rts_empty;
    @(posedge sys_clk) disable iff (rst)
    (auto_rts && trig != uaf_pkg::TRIG_14 &&
     rx_level == uaf_pkg::LVL_EMPTY && !rx_char_valid) [*2]
    |=> !rts_n_q;
  endproperty
  a_rts_empty: assert property (p_rts_empty)
    else $error("rts not back with empty queue");

  property p_rts_14_drop;
    @(posedge sys_clk) disable iff (rst)
    (auto_rts && trig == uaf_pkg::TRIG_14 && rx_first_data &&
     !rx_char_valid && rx_level == uaf_pkg::LVL_ONE_FREE)
    |=> ##1 (rts_n_q || $past(!auto_rts) ||
             $past(rx_level) != uaf_pkg::LVL_ONE_FREE);
  endproperty
  a_rts_14_drop: assert property (p_rts_14_drop)
    else $error("rts active during sixteenth character");

  property p_rts_14_room;
    @(posedge sys_clk) disable iff (rst)
    (auto_rts && trig == uaf_pkg::TRIG_14 &&
     rx_level <= uaf_pkg::LVL_14) |=> !rts_n_q;
  endproperty
  a_rts_14_room: assert property (p_rts_14_room)
    else $error("rts inactive with two free slots");

  property p_rts_14_slot;
    @(posedge sys_clk) disable iff (rst)
    (auto_rts && trig == uaf_pkg::TRIG_14 &&
     rx_level == uaf_pkg::LVL_ONE_FREE && !rx_inchar_q) |=> !rts_n_q;
  endproperty
  a_rts_14_slot: assert property (p_rts_14_slot)
    else $error("rts inactive with one idle free slot");

  property p_rx_extra;
    @(posedge sys_clk) disable iff (rst)
    (rx_char_valid && rx_level < uaf_pkg::LVL_FULL && !rx_pop)
    |=> rx_level == $past(rx_level) + 5'h01;
  endproperty
  a_rx_extra: assert property (p_rx_extra)
    else $error("character refused with room in rx queue");

  property p_dcts_set;
    @(posedge sys_clk) disable iff (rst)
    cts_changed |=> modem_status_q[uaf_pkg::MSR_DCTS_BIT] &&
      (modem_status_q[uaf_pkg::MSR_CTS_BIT] == $past(cts_active));
  endproperty
  a_dcts_set: assert property (p_dcts_set)
    else $error("cts change not reported");

  property p_no_irq_auto;
    @(posedge sys_clk) disable iff (rst)
    (auto_cts && !modem_irq_q) |=> !modem_irq_q;
  endproperty
  a_no_irq_auto: assert property (p_no_irq_auto)
    else $error("cts interrupt raised under auto cts");

  property p_rx_bound;
    @(posedge sys_clk) disable iff (rst)
    rx_level <= uaf_pkg::LVL_FULL;
  endproperty
  a_rx_bound: assert property (p_rx_bound)
    else $error("rx queue beyond sixteen");

  c_gated_send: cover property (@(posedge sys_clk) disable iff (rst)
    auto_cts && tx_out_valid && !cts_active ##[1:40] tx_start_q);
  c_rts_14: cover property (@(posedge sys_clk) disable iff (rst)
    auto_rts && trig == uaf_pkg::TRIG_14 && rts_n_q ##[1:40] !rts_n_q);
  c_overrun: cover property (@(posedge sys_clk) disable iff (rst)
    rx_overrun_q);
  c_irq: cover property (@(posedge sys_clk) disable iff (rst)
    modem_irq_q);
endmodule : uaf_autoflow

// >>> uaf_remote.sv
`timescale 1ns/10ps

// ==========================================================================
// far end of the rts/cts link
module uaf_remote (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic rts_n, // device rts, active low
  input wire logic cts_stop, // bench: hold cts inactive
  input wire logic eager, // bench: start without rts
  input wire logic slow, // bench: long char time
  input wire logic go, // bench: send one char
  input wire logic [10:0] byte_in, // bench: char to send
  input wire logic tx_start, // device launches a char
  output logic busy, // char in flight
  output logic cts_n, // clear to send, active low
  output logic tx_ready, // shifter idle
  output logic rx_first_data, // first data bit pulse
  output logic rx_char_valid, // char complete pulse
  output logic [10:0] rx_char // char plus error bits
);
  logic [3:0] cnt_q;
  logic [3:0] txc_q;
  logic [10:0] hold_q;

  // cts dropped by the bench right after a launch, ahead of stop bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      cts_n <= 1'b1;
    else
      cts_n <= cts_stop;
  end

  // shifter stays busy one character time after each launch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      txc_q <= 4'h0;
    else if (tx_start)
      txc_q <= slow ? 4'hf : 4'h3;
    else if (txc_q != 4'h0)
      txc_q <= txc_q - 4'h1;
  end
  assign tx_ready = (txc_q == 4'h0);

  // start only on rts, unless late sight of the drop is modelled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt_q <= 4'h0;
      hold_q <= 11'h000;
      rx_first_data <= 1'b0;
      rx_char_valid <= 1'b0;
      rx_char <= 11'h000;
    end else begin
      rx_first_data <= 1'b0;
      rx_char_valid <= 1'b0;
      // data lines do not keep the last value
      rx_char <= ~rx_char;
      if (go) begin
        busy <= 1'b1;
        cnt_q <= 4'h0;
        hold_q <= byte_in;
      end else if (busy && cnt_q == 4'h0 && (eager || !rts_n)) begin
        rx_first_data <= 1'b1;
        cnt_q <= 4'h1;
      end else if (busy && cnt_q != 4'h0) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'h8) begin
          rx_char_valid <= 1'b1;
          rx_char <= hold_q;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule : uaf_remote

// >>> uart_autoflow_rts_cts_tb.sv
`timescale 1ns/10ps

// ==========================================================================
// self-checking bench for the autoflow block
module uart_autoflow_rts_cts_tb;
  logic sys_clk;
  logic rst = 1'b1, fifo_mode = 1'b1, modem_irq_en = 1'b0;
  logic modem_status_rd = 1'b0, receive_buffer_rd = 1'b0;
  logic thr_wr_valid = 1'b0, cts_stop = 1'b1, eager = 1'b0;
  logic slow = 1'b0, go = 1'b0, busy, cts_n, tx_ready, rts_n_q;
  logic [7:0] modem_ctrl = 8'h00, thr_wr_data = 8'h00, tx_data_q;
  logic [7:0] modem_status_q;
  logic [1:0] rx_trigger = 2'b00;
  logic [10:0] byte_in = 11'h000, rx_char, receive_buffer_q;
  logic [4:0] rx_level_q;
  logic rx_first_data, rx_char_valid, rx_overrun_q, modem_irq_q;
  logic receive_buffer_vld_q, thr_wr_ready_q, tx_start_q, mid_rts;
  logic [10:0] mq[$], rxq[$], txq[$];
  int fail_count = 0, check_count = 0, tx_seen = 0;
  int ovr_seen = 0, ovr_exp = 0;

  // ==========================================================================
  // clock and instances
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  uaf_autoflow dut (.sys_clk(sys_clk), .rst(rst), .fifo_mode(fifo_mode),
    .modem_ctrl(modem_ctrl), .rx_trigger(rx_trigger),
    .modem_irq_en(modem_irq_en), .modem_status_rd(modem_status_rd),
    .cts_n(cts_n), .rts_n_q(rts_n_q), .modem_status_q(modem_status_q),
    .modem_irq_q(modem_irq_q), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_first_data(rx_first_data),
    .rx_overrun_q(rx_overrun_q), .receive_buffer_rd(receive_buffer_rd),
    .receive_buffer_q(receive_buffer_q),
    .receive_buffer_vld_q(receive_buffer_vld_q), .rx_level_q(rx_level_q),
    .thr_wr_valid(thr_wr_valid), .thr_wr_data(thr_wr_data),
    .thr_wr_ready_q(thr_wr_ready_q), .tx_ready(tx_ready),
    .tx_start_q(tx_start_q), .tx_data_q(tx_data_q));

  uaf_remote far (.sys_clk(sys_clk), .rst(rst), .rts_n(rts_n_q),
    .cts_stop(cts_stop), .eager(eager), .slow(slow), .go(go),
    .byte_in(byte_in), .tx_start(tx_start_q), .busy(busy), .cts_n(cts_n),
    .tx_ready(tx_ready), .rx_first_data(rx_first_data),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  // ==========================================================================
  // reporting
  task automatic cmp(input string n, input logic [10:0] e,
                     input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic timeout(input string n);
    fail_count++;
    $display("unexpected %s: expected done seen timeout", n);
    give_verdict();
  endtask : timeout

  // ==========================================================================
  // drivers; each starts on a rising edge except wait_tx, which polls on falling edges
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : tick

  task automatic ctl(input logic f, input logic [7:0] mc,
                     input logic [1:0] tr, input logic cs, input logic ie);
    @(posedge sys_clk);
    fifo_mode <= f;
    modem_ctrl <= mc;
    rx_trigger <= tr;
    cts_stop <= cs;
    modem_irq_en <= ie;
  endtask : ctl

  // far end sends one char; notes what the queue should hold
  task automatic send(input logic early);
    logic [10:0] b;
    int k;
    b = 11'($urandom);
    @(posedge sys_clk);
    go <= 1'b1;
    byte_in <= b;
    eager <= early;
    @(posedge sys_clk);
    go <= 1'b0;
    for (k = 0; k < 200 && rx_first_data !== 1'b1; k++) @(negedge sys_clk);
    if (k == 200)
      timeout("rx_first_data");
    repeat (3) @(negedge sys_clk);
    mid_rts = rts_n_q;
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge sys_clk);
    if (k == 200)
      timeout("rx_send");
    if (mq.size() < 16)
      mq.push_back(b);
    else
      ovr_exp++;
  endtask : send

  task automatic rd_n(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      receive_buffer_rd <= 1'b1;
      if (mq.size() > 0)
        rxq.push_back(mq.pop_front());
    end
    @(posedge sys_clk);
    receive_buffer_rd <= 1'b0;
  endtask : rd_n

  task automatic wr(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      thr_wr_valid <= 1'b1;
      thr_wr_data <= 8'($urandom);
      @(negedge sys_clk);
      txq.push_back({3'h0, thr_wr_data});
    end
    @(posedge sys_clk);
    thr_wr_valid <= 1'b0;
  endtask : wr

  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 400 && tx_seen != n; k++) @(negedge sys_clk);
    if (k == 400)
      timeout("tx_count");
  endtask : wait_tx

  task automatic msr_rd;
    @(posedge sys_clk);
    modem_status_rd <= 1'b1;
    @(posedge sys_clk);
    modem_status_rd <= 1'b0;
  endtask : msr_rd

  // ==========================================================================
  // monitor: each result taken against the oldest note
  always @(posedge sys_clk) begin
    #1;
    if (receive_buffer_vld_q === 1'b1)
      cmp("receive_buffer_q", rxq.size() ? rxq.pop_front() : 'x,
          receive_buffer_q);
    if (tx_start_q === 1'b1) begin
      tx_seen++;
      cmp("tx_data_q", txq.size() ? txq.pop_front() : 'x,
          {3'h0, tx_data_q});
    end
    if (rx_overrun_q === 1'b1)
      ovr_seen++;
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h1dce));
    tick(5);
    cmp("rts_n_q", 11'h001, 11'(rts_n_q));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    ctl(1'b1, 8'h02, 2'b00, 1'b1, 1'b0);
    tick(3);
    cmp("rts_n_q", 11'h000, 11'(rts_n_q));
    cmp("thr_wr_ready_q", 11'h001, 11'(thr_wr_ready_q));
    // trigger levels 1, 4 and 8 with one late char each
    for (int t = 0; t < 3; t++) begin
      ctl(1'b1, 8'h22, 2'(t), 1'b1, 1'b0);
      for (int i = 0; i < (t == 0 ? 1 : 4 * t); i++) send(1'b0);
      tick(4);
      cmp("rts_n_q", 11'h001, 11'(rts_n_q));
      send(1'b1);
      rd_n(mq.size() - 1);
      tick(4);
      cmp("rts_n_q", 11'h001, 11'(rts_n_q));
      // last read plus one read of the empty queue
      rd_n(2);
      tick(4);
      cmp("rts_n_q", 11'h000, 11'(rts_n_q));
    end
    // trigger 14: in-progress sixteenth char, overrun, first read
    ctl(1'b1, 8'h22, 2'b11, 1'b1, 1'b0);
    repeat (15) send(1'b0);
    tick(3);
    cmp("rts_n_q", 11'h000, 11'(rts_n_q));
    cmp("rx_level_q", 11'h00f, 11'(rx_level_q));
    send(1'b0);
    cmp("rts_n_q", 11'h001, 11'(mid_rts));
    send(1'b1);
    tick(3);
    cmp("rx_overrun_q", 11'(ovr_exp), 11'(ovr_seen));
    rd_n(1);
    tick(3);
    cmp("rts_n_q", 11'h000, 11'(rts_n_q));
    rd_n(16);
    // auto cts only, cts inactive: nothing may start
    ctl(1'b1, 8'h20, 2'b11, 1'b1, 1'b0);
    wr(3);
    tick(20);
    cmp("tx_count", 11'h000, 11'(tx_seen));
    ctl(1'b1, 8'h20, 2'b11, 1'b0, 1'b0);
    wait_tx(3);
    cmp("tx_count", 11'h003, 11'(tx_seen));
    slow <= 1'b1;
    wr(2);
    wait_tx(4);
    ctl(1'b1, 8'h20, 2'b11, 1'b1, 1'b0);
    tick(30);
    cmp("tx_count", 11'h004, 11'(tx_seen));
    slow <= 1'b0;
    // no auto cts, then fifo mode off: queued chars go anyway
    for (int m = 0; m < 2; m++) begin
      ctl(m == 0, m == 0 ? 8'h02 : 8'h22, 2'b11, 1'b1, 1'b0);
      wr(2);
      wait_tx(7 + 2 * m);
      cmp("tx_count", 11'(7 + 2 * m), 11'(tx_seen));
    end
    // modem status with and without auto cts
    msr_rd();
    ctl(1'b1, 8'h02, 2'b11, 1'b0, 1'b1);
    tick(6);
    cmp("modem_status_q", 11'h011, 11'(modem_status_q));
    cmp("modem_irq_q", 11'h001, 11'(modem_irq_q));
    msr_rd();
    tick(2);
    cmp("modem_status_q", 11'h010, 11'(modem_status_q));
    cmp("modem_irq_q", 11'h000, 11'(modem_irq_q));
    ctl(1'b1, 8'h22, 2'b11, 1'b1, 1'b1);
    tick(6);
    cmp("modem_status_q", 11'h001, 11'(modem_status_q));
    cmp("modem_irq_q", 11'h000, 11'(modem_irq_q));
    give_verdict();
  end
endmodule : uart_autoflow_rts_cts_tb
